// ---- design/adcr_pkg.sv ----
package adcr_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'h40;
    localparam logic [7:0] ADDR_WA_HI = 8'h41;
    localparam logic [7:0] ADDR_WA_LO = 8'h42;
    localparam logic [7:0] ADDR_WB_HI = 8'h43;
    localparam logic [7:0] ADDR_WB_LO = 8'h44;
    localparam logic [7:0] ADDR_NB_CFG = 8'h45;
    localparam logic [7:0] ADDR_NB_HI = 8'h46;
    localparam logic [7:0] ADDR_NB_LO = 8'h47;
    localparam int BIT_WB_PWR = 7;
    localparam int BIT_WA_PWR = 6;
    localparam int BIT_WB_RNG = 5;
    localparam int BIT_WA_RNG = 4;
    localparam int BIT_REF_SEL = 1;
    localparam int BIT_UPD_SEL = 0;
    localparam int BIT_NB_PWR = 7;
    localparam int NB_TOP_MSB = 4;
    localparam int NB_TOP_LSB = 2;
    localparam int NB_SPAN_MSB = 1;
    localparam int NB_SPAN_LSB = 0;
    localparam int WIDE_LO_MSB = 3;
    localparam int NARROW_LO_MSB = 1;
    localparam logic [7:0] CONFIG_MASK = 8'hF3;
    localparam logic [7:0] NIBBLE_MASK = 8'h0F;
    localparam logic [7:0] NB_CFG_MASK = 8'h9F;
    localparam logic [7:0] NB_LO_MASK = 8'h03;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } adcr_wr_t;

    typedef struct packed {
        logic wide_a_power_on;
        logic wide_b_power_on;
        logic wide_a_range_sel;
        logic wide_b_range_sel;
        logic aux_reference_sel;
        logic narrow_b_power_on;
        logic [2:0] narrow_b_top_level;
        logic [1:0] narrow_b_span;
        logic [11:0] wide_aux_out_a;
        logic [11:0] wide_aux_out_b;
        logic [9:0] narrow_aux_out_b;
    } adcr_analog_t;

    typedef struct packed {
        logic [7:0] config_r;
        logic [7:0] wa_hi;
        logic [7:0] wa_lo;
        logic [7:0] wb_hi;
        logic [7:0] wb_lo;
        logic [7:0] nb_cfg;
        logic [7:0] nb_hi;
        logic [7:0] nb_lo;
        logic [11:0] wa_code;
        logic [11:0] wb_code;
        logic [9:0] nb_code;
        logic [7:0] rdata;
    } adcr_state_t;
endpackage

// ---- design/adcr_regs.sv ----
// Summary of operation
// - Config bits 7,6 power wide outputs B, A
// - Bit 5 sets wide B range
// - Bit 4 sets wide A range
// - Bit 1 picks shared auxiliary reference
// - Bit 0 picks high or low trigger write
// - 0x41 holds wide A bits 11:4
// - 0x42 low nibble holds wide A 3:0
// - 0x43 holds wide B bits 11:4
// - 0x44 low nibble holds wide B 3:0
// - 0x45 bit 7 powers narrow B
// - 0x45 bits 4:2 set narrow B top
// - 0x45 bits 1:0 set narrow B span
// - Narrow B word split 0x46 and 0x47
module adcr_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire adcr_pkg::adcr_wr_t wr_in,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output adcr_pkg::adcr_analog_t analog
);
    adcr_pkg::adcr_state_t state_reg;
    adcr_pkg::adcr_state_t state_next;
    logic hit_hi;
    logic hit_lo;
    logic update;

    always_comb begin
        state_next = state_reg;
        hit_hi = wr_in.wr && (wr_in.addr == adcr_pkg::ADDR_WA_HI || wr_in.addr == adcr_pkg::ADDR_WB_HI
            || wr_in.addr == adcr_pkg::ADDR_NB_HI);
        hit_lo = wr_in.wr && (wr_in.addr == adcr_pkg::ADDR_WA_LO || wr_in.addr == adcr_pkg::ADDR_WB_LO
            || wr_in.addr == adcr_pkg::ADDR_NB_LO);
        // Trigger chosen by config bit 0
        update = state_reg.config_r[adcr_pkg::BIT_UPD_SEL] ? hit_hi : hit_lo;
        if (wr_in.wr) begin
            if (wr_in.addr == adcr_pkg::ADDR_CONFIG) begin
                state_next.config_r = wr_in.data & adcr_pkg::CONFIG_MASK;
            end else if (wr_in.addr == adcr_pkg::ADDR_WA_HI) begin
                state_next.wa_hi = wr_in.data;
            end else if (wr_in.addr == adcr_pkg::ADDR_WA_LO) begin
                state_next.wa_lo = wr_in.data & adcr_pkg::NIBBLE_MASK;
            end else if (wr_in.addr == adcr_pkg::ADDR_WB_HI) begin
                state_next.wb_hi = wr_in.data;
            end else if (wr_in.addr == adcr_pkg::ADDR_WB_LO) begin
                state_next.wb_lo = wr_in.data & adcr_pkg::NIBBLE_MASK;
            end else if (wr_in.addr == adcr_pkg::ADDR_NB_CFG) begin
                state_next.nb_cfg = wr_in.data & adcr_pkg::NB_CFG_MASK;
            end else if (wr_in.addr == adcr_pkg::ADDR_NB_HI) begin
                state_next.nb_hi = wr_in.data;
            end else if (wr_in.addr == adcr_pkg::ADDR_NB_LO) begin
                state_next.nb_lo = wr_in.data & adcr_pkg::NB_LO_MASK;
            end
        end
        // Live codes change only on the trigger write, using the freshly written byte
        if (update) begin
            state_next.wa_code = {state_next.wa_hi, state_next.wa_lo[adcr_pkg::WIDE_LO_MSB:0]};
            state_next.wb_code = {state_next.wb_hi, state_next.wb_lo[adcr_pkg::WIDE_LO_MSB:0]};
            state_next.nb_code = {state_next.nb_hi, state_next.nb_lo[adcr_pkg::NARROW_LO_MSB:0]};
        end
        if (rd_addr == adcr_pkg::ADDR_CONFIG) begin
            state_next.rdata = state_next.config_r;
        end else if (rd_addr == adcr_pkg::ADDR_WA_HI) begin
            state_next.rdata = state_next.wa_hi;
        end else if (rd_addr == adcr_pkg::ADDR_WA_LO) begin
            state_next.rdata = state_next.wa_lo;
        end else if (rd_addr == adcr_pkg::ADDR_WB_HI) begin
            state_next.rdata = state_next.wb_hi;
        end else if (rd_addr == adcr_pkg::ADDR_WB_LO) begin
            state_next.rdata = state_next.wb_lo;
        end else if (rd_addr == adcr_pkg::ADDR_NB_CFG) begin
            state_next.rdata = state_next.nb_cfg;
        end else if (rd_addr == adcr_pkg::ADDR_NB_HI) begin
            state_next.rdata = state_next.nb_hi;
        end else if (rd_addr == adcr_pkg::ADDR_NB_LO) begin
            state_next.rdata = state_next.nb_lo;
        end else begin
            state_next.rdata = adcr_pkg::RESET_BYTE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.rdata;

    always_comb begin
        analog.wide_b_power_on = state_reg.config_r[adcr_pkg::BIT_WB_PWR];
        analog.wide_a_power_on = state_reg.config_r[adcr_pkg::BIT_WA_PWR];
        analog.wide_b_range_sel = state_reg.config_r[adcr_pkg::BIT_WB_RNG];
        analog.wide_a_range_sel = state_reg.config_r[adcr_pkg::BIT_WA_RNG];
        analog.aux_reference_sel = state_reg.config_r[adcr_pkg::BIT_REF_SEL];
        analog.narrow_b_power_on = state_reg.nb_cfg[adcr_pkg::BIT_NB_PWR];
        analog.narrow_b_top_level = state_reg.nb_cfg[adcr_pkg::NB_TOP_MSB:adcr_pkg::NB_TOP_LSB];
        analog.narrow_b_span = state_reg.nb_cfg[adcr_pkg::NB_SPAN_MSB:adcr_pkg::NB_SPAN_LSB];
        analog.wide_aux_out_a = state_reg.wa_code;
        analog.wide_aux_out_b = state_reg.wb_code;
        analog.narrow_aux_out_b = state_reg.nb_code;
    end
endmodule // adcr_regs

// ---- verif/adcr_regs_props.sv ----
module adcr_regs_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire adcr_pkg::adcr_wr_t wr_in,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire adcr_pkg::adcr_analog_t analog
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic w;
    logic upd_hi_reg;
    logic [7:0] a;
    assign w = wr_in.wr && clk_en;
    assign a = wr_in.addr;
    // Tracks which write half fires the load
    always_ff @(posedge clk) begin
        if (sys_rst) upd_hi_reg <= 1'b0;
        else if (w && a == 8'h40) upd_hi_reg <= wr_in.data[0];
    end
    pwr_bits_a: assert property (w && a == 8'h40 |=> {analog.wide_b_power_on, analog.wide_a_power_on,
        analog.wide_b_range_sel, analog.wide_a_range_sel} == $past(wr_in.data[7:4])) else $error("cfg bits");
    ref_sel_a: assert property (w && a == 8'h40 |=> analog.aux_reference_sel == $past(wr_in.data[1])) else $error("ref");
    nb_cfg_a: assert property (w && a == 8'h45 |=> {analog.narrow_b_power_on, analog.narrow_b_top_level,
        analog.narrow_b_span} == {$past(wr_in.data[7]), $past(wr_in.data[4:0])}) else $error("nb cfg");
    unused_zero_a: assert property (clk_en && rd_addr inside {8'h42, 8'h44} |=> rd_data[7:4] == 4'h0) else $error("rd");
    hold_codes_a: assert property (!w |=> $stable(analog.wide_aux_out_a) && $stable(analog.wide_aux_out_b)) else $error("hold");
    trig_lo_a: assert property (w && a == 8'h44 && !upd_hi_reg |=> analog.wide_aux_out_b[3:0] == $past(wr_in.data[3:0]))
        else $error("lo trig");
    trig_hi_a: assert property (w && a == 8'h41 && upd_hi_reg |=> analog.wide_aux_out_a[11:4] == $past(wr_in.data))
        else $error("hi trig");
    shadow_a: assert property (w && a == 8'h43 && !upd_hi_reg |=> $stable(analog.wide_aux_out_b)) else $error("shadow");
    nb_code_a: assert property (w && a == 8'h47 && !upd_hi_reg |=> analog.narrow_aux_out_b[1:0] == $past(wr_in.data[1:0]))
        else $error("nb code");
    cover property (w && a == 8'h41 && upd_hi_reg);
    cover property (w && a == 8'h44 && !upd_hi_reg);
    cover property (w && a == 8'h47);
    cover property (!clk_en && wr_in.wr);
endmodule // adcr_regs_props
bind adcr_regs adcr_regs_props props_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .wr_in(wr_in),
    .rd_addr(rd_addr), .rd_data(rd_data), .analog(analog));

// ---- verif/aux_dac_control_regs_tb_top.sv ----
module aux_dac_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, clk_en = 1;
    adcr_pkg::adcr_wr_t wr_in = '0;
    logic [7:0] rd_addr = '0;
    logic [7:0] rd_data;
    adcr_pkg::adcr_analog_t analog;
    int miscompares = 0, tests_run = 0;
    adcr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .wr_in(wr_in), .rd_addr(rd_addr),
        .rd_data(rd_data), .analog(analog));
    always #5 clk = ~clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        wr_in <= '{1'b1, ad, d};
        @(posedge clk);
        wr_in.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        rd_addr <= ad;
        @(posedge clk);
        @(negedge clk);
        chk(16'(rd_data), 16'(e), "rd_data");
        @(posedge clk);
    endtask
    task automatic t_hi_trig;
        wr(8'h40, 8'hFF);
        chk(16'({analog.wide_a_power_on, analog.wide_b_power_on, analog.wide_a_range_sel,
            analog.wide_b_range_sel, analog.aux_reference_sel}), 16'h001F, "cfg");
        rd(8'h40, 8'hF3);
        wr(8'h42, 8'hFC);
        chk(16'(analog.wide_aux_out_a), 16'h0000, "wa held");
        wr(8'h41, 8'hAB);
        chk(16'(analog.wide_aux_out_a), 16'h0ABC, "wa");
    endtask
    task automatic t_lo_trig;
        wr(8'h40, 8'h00);
        chk(16'(analog.wide_b_power_on), 16'h0000, "wb pwr");
        wr(8'h43, 8'h12);
        chk(16'(analog.wide_aux_out_b), 16'h0000, "wb held");
        wr(8'h44, 8'h34);
        chk(16'(analog.wide_aux_out_b), 16'h0124, "wb");
        rd(8'h44, 8'h04);
        rd(8'h50, 8'h00);
    endtask
    task automatic t_narrow;
        wr(8'h45, 8'hFF);
        rd(8'h45, 8'h9F);
        chk(16'({analog.narrow_b_power_on, analog.narrow_b_top_level, analog.narrow_b_span}), 16'h003F,
            "nb cfg");
        wr(8'h46, 8'h5A);
        wr(8'h47, 8'hFF);
        chk(16'(analog.narrow_aux_out_b), 16'h016B, "nb");
    endtask
    task automatic t_freeze;
        clk_en <= 1'b0;
        wr(8'h41, 8'h55);
        clk_en <= 1'b1;
        chk(16'(analog.wide_aux_out_a), 16'h0ABC, "frozen wa");
        rd(8'h41, 8'hAB);
    endtask
    task automatic t_reset;
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h40, 8'h00);
        chk(16'(analog.wide_aux_out_a), 16'h0000, "wa after reset");
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000 miscompares++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_hi_trig();
        t_lo_trig();
        t_freeze();
        t_reset();
        t_narrow();
        wrap_up();
    end
endmodule // aux_dac_control_regs_tb_top
